// >>> rtl/wfm_acq.sv
`timescale 1ns/1ps
`include "wfm_acq_map.svh"

module wfm_acq (
  // Clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  // Register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  // ADC sample stream
  input  wire logic [`SAMPLE_W-1:0]   i_adc_data,
  input  wire logic                   i_adc_valid,
  output logic                        o_adc_ready,
  input  wire logic                   i_trigger,
  input  wire logic [15:0]            i_time_per_div,
  // Waveform point stream
  output logic [`SAMPLE_W-1:0]        o_pt_lo,
  output logic [`SAMPLE_W-1:0]        o_pt_hi,
  output logic [`RECLEN_W-1:0]        o_pt_index,
  output logic                        o_pt_valid,
  input  wire logic                   i_pt_ready,
  // Status
  output logic                        o_rolling,
  output logic                        o_zoom_allowed,
  output logic                        o_running
);

  localparam int SW = `SAMPLE_W;
  localparam int AW = `ACC_W;
  localparam int RW = `RECLEN_W;
  localparam int MAXREC = 1024;

  // Unsigned min and max over two samples
  function automatic logic [SW-1:0] min2(input logic [SW-1:0] a, input logic [SW-1:0] b);
    min2 = (a < b) ? a : b;
  endfunction
  function automatic logic [SW-1:0] max2(input logic [SW-1:0] a, input logic [SW-1:0] b);
    max2 = (a > b) ? a : b;
  endfunction

  // Configuration registers
  logic [5:0]                ctrl_q, ctrl_d;
  wfm_acq_pkg::acq_mode_e    mode_q, mode_d;
  logic [15:0]               ratio_q, ratio_d;
  logic [RW-1:0]             reclen_q, reclen_d;
  logic [7:0]                avgcnt_q, avgcnt_d;
  logic [7:0]                nsingle_q, nsingle_d;
  logic [15:0]               roll_q, roll_d;
  logic [31:0]               rdata_q, rdata_d;
  logic                      clear_pulse;

  always_comb begin
    ctrl_d    = ctrl_q;
    mode_d    = mode_q;
    ratio_d   = ratio_q;
    reclen_d  = reclen_q;
    avgcnt_d  = avgcnt_q;
    nsingle_d = nsingle_q;
    roll_d    = roll_q;
    // Single start and clear are self-clearing strobes
    ctrl_d[`CTRL_SINGLE] = 1'b0;
    ctrl_d[`CTRL_CLEAR]  = 1'b0;
    if (i_wr) begin
      case (i_addr)
        `ADDR_CTRL:    ctrl_d    = i_wdata[5:0];
        `ADDR_MODE:    mode_d    = wfm_acq_pkg::acq_mode_e'(i_wdata[2:0]);
        `ADDR_RATIO:   ratio_d   = (i_wdata[15:0] == 16'h0000) ? 16'h0001 : i_wdata[15:0];
        `ADDR_RECLEN:  reclen_d  = i_wdata[RW-1:0];
        `ADDR_AVGCNT:  avgcnt_d  = (i_wdata[7:0] == 8'h00) ? 8'h01 : i_wdata[7:0];
        `ADDR_NSINGLE: nsingle_d = (i_wdata[7:0] == 8'h00) ? 8'h01 : i_wdata[7:0];
        `ADDR_ROLL:    roll_d    = i_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  assign clear_pulse = ctrl_q[`CTRL_CLEAR];

  // State
  wfm_acq_pkg::acq_state_e   st_q, st_d;
  logic [7:0]                acq_cnt_q, acq_cnt_d;
  logic [7:0]                avg_n_q, avg_n_d;
  logic [15:0]               grp_cnt_q, grp_cnt_d;
  logic [AW-1:0]             grp_sum_q, grp_sum_d;
  logic [SW-1:0]             grp_min_q, grp_min_d;
  logic [SW-1:0]             grp_max_q, grp_max_d;
  logic [RW-1:0]             pt_idx_q, pt_idx_d;
  logic                      env_first_q, env_first_d;
  logic                      rolling_q, rolling_d;
  logic [SW-1:0]             mem_lo_q [MAXREC];
  logic [SW-1:0]             mem_hi_q [MAXREC];
  logic [AW-1:0]             mem_acc_q [MAXREC];
  logic [SW-1:0]             last_q, last_d;

  // Two-entry output buffer
  logic [SW-1:0]             buf_lo_q [2];
  logic [SW-1:0]             buf_hi_q [2];
  logic [RW-1:0]             buf_ix_q [2];
  logic [1:0]                buf_cnt_q, buf_cnt_d;
  logic                      buf_wp_q, buf_wp_d, buf_rp_q, buf_rp_d;
  logic                      push, pop;
  logic [SW-1:0]             push_lo, push_hi;
  logic                      out_valid_q, out_valid_d;
  logic [SW-1:0]             out_lo_q, out_lo_d, out_hi_q, out_hi_d;
  logic [RW-1:0]             out_ix_q, out_ix_d;

  logic                      grp_end, in_take, running;
  logic [RW-1:0]             eff_len;
  logic [SW-1:0]             s_lo, s_hi, g_mean, c_lo, c_hi;
  logic [AW-1:0]             new_acc;
  logic [15:0]               interp_cnt_q, interp_cnt_d;
  wfm_acq_pkg::acq_mode_e    cap_mode;

  assign running = (st_q == wfm_acq_pkg::ST_RUN);
  // Stall the ADC side whenever the output buffer cannot accept a point
  assign in_take = i_adc_valid && buf_cnt_q != 2'd2 && running && interp_cnt_q == 16'h0000;

  always_comb begin
    rolling_d = ctrl_q[`CTRL_ROLLEN] && (i_time_per_div >= roll_q);
    // roll forces auto length; auto or manual length
    eff_len = (rolling_q || ctrl_q[`CTRL_RECAUTO]) ? `RST_AUTO_RECLEN : reclen_q;
    if (eff_len > RW'(MAXREC)) begin
      eff_len = RW'(MAXREC);
    end
    grp_end = (grp_cnt_q + 16'h0001 >= ratio_q);
    // Per-acquisition capture flavour of each mode
    case (mode_q)
      wfm_acq_pkg::MODE_MINMAX, wfm_acq_pkg::MODE_ENV_PD:    cap_mode = wfm_acq_pkg::MODE_MINMAX;
      wfm_acq_pkg::MODE_GROUP_AVG, wfm_acq_pkg::MODE_AVG_HR,
      wfm_acq_pkg::MODE_ENV_HR:                              cap_mode = wfm_acq_pkg::MODE_GROUP_AVG;
      default:                                               cap_mode = wfm_acq_pkg::MODE_SAMPLE;
    endcase
    g_mean = SW'((grp_sum_q + AW'(i_adc_data)) / AW'(ratio_q));
    case (cap_mode)
      wfm_acq_pkg::MODE_MINMAX: begin
        s_lo = min2(grp_min_q, i_adc_data);
        s_hi = max2(grp_max_q, i_adc_data);
      end
      wfm_acq_pkg::MODE_GROUP_AVG: begin
        s_lo = g_mean;
        s_hi = g_mean;
      end
      default: begin
        s_lo = (grp_cnt_q == 16'h0000) ? i_adc_data : grp_min_q;
        s_hi = s_lo;
      end
    endcase
    if (grp_cnt_q == 16'h0000 && cap_mode == wfm_acq_pkg::MODE_MINMAX) begin
      s_lo = i_adc_data;
      s_hi = i_adc_data;
    end
    new_acc = env_first_q ? AW'(s_lo) : mem_acc_q[pt_idx_q[9:0]] + AW'(s_lo) -
              ((avg_n_q > avgcnt_q) ? mem_acc_q[pt_idx_q[9:0]] / AW'(avgcnt_q) : AW'(0));
    c_lo = s_lo;
    c_hi = s_hi;
    case (mode_q)
      wfm_acq_pkg::MODE_AVERAGE, wfm_acq_pkg::MODE_AVG_HR: begin
        c_lo = SW'(new_acc / AW'(env_first_q ? 8'h01 : ((avg_n_q > avgcnt_q) ? avgcnt_q : avg_n_q)));
        c_hi = c_lo;
      end
      wfm_acq_pkg::MODE_ENV, wfm_acq_pkg::MODE_ENV_PD, wfm_acq_pkg::MODE_ENV_HR: begin
        if (!env_first_q) begin
          c_lo = min2(mem_lo_q[pt_idx_q[9:0]], s_lo);
          c_hi = max2(mem_hi_q[pt_idx_q[9:0]], s_hi);
        end
      end
      default: begin
      end
    endcase
  end

  always_comb begin
    st_d         = st_q;
    acq_cnt_d    = acq_cnt_q;
    avg_n_d      = avg_n_q;
    grp_cnt_d    = grp_cnt_q;
    grp_sum_d    = grp_sum_q;
    grp_min_d    = grp_min_q;
    grp_max_d    = grp_max_q;
    pt_idx_d     = pt_idx_q;
    env_first_d  = env_first_q;
    last_d       = last_q;
    interp_cnt_d = interp_cnt_q;
    push         = 1'b0;
    push_lo      = c_lo;
    push_hi      = c_hi;
    case (st_q)
      wfm_acq_pkg::ST_IDLE, wfm_acq_pkg::ST_DONE: begin
        if (ctrl_q[`CTRL_RUN] || ctrl_q[`CTRL_SINGLE]) begin
          st_d      = wfm_acq_pkg::ST_RUN;
          acq_cnt_d = 8'h00;
          pt_idx_d  = '0;
          grp_cnt_d = 16'h0000;
        end
      end
      wfm_acq_pkg::ST_RUN: begin
        if (in_take) begin
          grp_sum_d = (grp_cnt_q == 16'h0000) ? AW'(i_adc_data) : grp_sum_q + AW'(i_adc_data);
          grp_min_d = s_lo;
          grp_max_d = s_hi;
          grp_cnt_d = grp_cnt_q + 16'h0001;
          if (grp_end) begin
            grp_cnt_d = 16'h0000;
            push      = 1'b1;
            last_d    = c_lo;
            // roll streams raw points with no record wrap wait
            if (rolling_q) begin
              push_lo = s_lo;
              push_hi = s_hi;
            end
            pt_idx_d = pt_idx_q + RW'(1);
            if (pt_idx_q + RW'(1) >= eff_len && !rolling_q) begin
              pt_idx_d    = '0;
              env_first_d = 1'b0;
              acq_cnt_d   = acq_cnt_q + 8'h01;
              if (avg_n_q <= avgcnt_q && avg_n_q != 8'hff) begin
                avg_n_d = avg_n_q + 8'h01;
              end
              if (!ctrl_q[`CTRL_RUN] && acq_cnt_q + 8'h01 >= nsingle_q) begin
                st_d = wfm_acq_pkg::ST_DONE;
              end
            end
            if (rolling_q && pt_idx_q + RW'(1) >= eff_len) begin
              pt_idx_d = '0;
            end
          end
        end else if (interp_cnt_q != 16'h0000 && buf_cnt_q != 2'd2) begin
          push         = 1'b1;
          push_lo      = last_q;
          push_hi      = last_q;
          interp_cnt_d = interp_cnt_q - 16'h0001;
        end
        if (i_wr && i_addr == `ADDR_CTRL && !i_wdata[`CTRL_RUN] && !i_wdata[`CTRL_SINGLE]) begin
          st_d = wfm_acq_pkg::ST_IDLE;
        end
      end
      default: st_d = wfm_acq_pkg::ST_IDLE;
    endcase
    if (clear_pulse) begin
      env_first_d = 1'b1;
      avg_n_d     = 8'h01;
      pt_idx_d    = '0;
    end
  end

  // Output buffer control
  assign pop = out_valid_q ? (i_pt_ready && buf_cnt_q != 2'd0) : (buf_cnt_q != 2'd0);

  always_comb begin
    buf_cnt_d   = buf_cnt_q + (push ? 2'd1 : 2'd0) - (pop ? 2'd1 : 2'd0);
    buf_wp_d    = push ? ~buf_wp_q : buf_wp_q;
    buf_rp_d    = pop ? ~buf_rp_q : buf_rp_q;
    out_valid_d = out_valid_q;
    out_lo_d    = out_lo_q;
    out_hi_d    = out_hi_q;
    out_ix_d    = out_ix_q;
    if (out_valid_q && i_pt_ready) begin
      out_valid_d = 1'b0;
    end
    if (pop) begin
      out_valid_d = 1'b1;
      out_lo_d    = buf_lo_q[buf_rp_q];
      out_hi_d    = buf_hi_q[buf_rp_q];
      out_ix_d    = buf_ix_q[buf_rp_q];
    end
    rdata_d = 32'h0000_0000;
    if (i_rd) begin
      case (i_addr)
        `ADDR_CTRL:    rdata_d = {26'h0, ctrl_q};
        `ADDR_MODE:    rdata_d = {29'h0, mode_q};
        `ADDR_RATIO:   rdata_d = {16'h0, ratio_q};
        `ADDR_RECLEN:  rdata_d = {16'h0, eff_len};
        `ADDR_AVGCNT:  rdata_d = {24'h0, avgcnt_q};
        `ADDR_NSINGLE: rdata_d = {24'h0, nsingle_q};
        `ADDR_ROLL:    rdata_d = {16'h0, roll_q};
        `ADDR_STATUS:  rdata_d = {28'h0, (rolling_q && !running), rolling_q, st_q};
        `ADDR_ACQDONE: rdata_d = {16'h0, avg_n_q, acq_cnt_q};
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_q       <= 6'h08;
      mode_q       <= wfm_acq_pkg::MODE_SAMPLE;
      ratio_q      <= `RST_RATIO;
      reclen_q     <= `RST_RECLEN;
      avgcnt_q     <= `RST_AVGCNT;
      nsingle_q    <= `RST_NSINGLE;
      roll_q       <= `RST_ROLL;
      rdata_q      <= 32'h0000_0000;
      st_q         <= wfm_acq_pkg::ST_IDLE;
      acq_cnt_q    <= 8'h00;
      avg_n_q      <= 8'h01;
      grp_cnt_q    <= 16'h0000;
      grp_sum_q    <= '0;
      grp_min_q    <= '0;
      grp_max_q    <= '0;
      pt_idx_q     <= '0;
      env_first_q  <= 1'b1;
      rolling_q    <= 1'b0;
      last_q       <= '0;
      interp_cnt_q <= 16'h0000;
      buf_cnt_q    <= 2'd0;
      buf_wp_q     <= 1'b0;
      buf_rp_q     <= 1'b0;
      out_valid_q  <= 1'b0;
      out_lo_q     <= '0;
      out_hi_q     <= '0;
      out_ix_q     <= '0;
    end else begin
      ctrl_q       <= ctrl_d;
      mode_q       <= mode_d;
      ratio_q      <= ratio_d;
      reclen_q     <= reclen_d;
      avgcnt_q     <= avgcnt_d;
      nsingle_q    <= nsingle_d;
      roll_q       <= roll_d;
      rdata_q      <= rdata_d;
      st_q         <= st_d;
      acq_cnt_q    <= acq_cnt_d;
      avg_n_q      <= avg_n_d;
      grp_cnt_q    <= grp_cnt_d;
      grp_sum_q    <= grp_sum_d;
      grp_min_q    <= grp_min_d;
      grp_max_q    <= grp_max_d;
      pt_idx_q     <= pt_idx_d;
      env_first_q  <= env_first_d;
      rolling_q    <= rolling_d;
      last_q       <= last_d;
      interp_cnt_q <= interp_cnt_d;
      buf_cnt_q    <= buf_cnt_d;
      buf_wp_q     <= buf_wp_d;
      buf_rp_q     <= buf_rp_d;
      out_valid_q  <= out_valid_d;
      out_lo_q     <= out_lo_d;
      out_hi_q     <= out_hi_d;
      out_ix_q     <= out_ix_d;
    end
  end

  // Storage arrays carry no reset; envelope/average first pass overwrites them
  always_ff @(posedge i_clk) begin
    if (push && in_take) begin
      mem_lo_q[pt_idx_q[9:0]]  <= c_lo;
      mem_hi_q[pt_idx_q[9:0]]  <= c_hi;
      mem_acc_q[pt_idx_q[9:0]] <= new_acc;
    end
    if (push) begin
      buf_lo_q[buf_wp_q] <= push_lo;
      buf_hi_q[buf_wp_q] <= push_hi;
      buf_ix_q[buf_wp_q] <= pt_idx_q;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_pt_lo        = out_lo_q;
  assign o_pt_hi        = out_hi_q;
  assign o_pt_index     = out_ix_q;
  assign o_pt_valid     = out_valid_q;
  assign o_rolling      = rolling_q;
  // zoom only when stopped in roll
  assign o_zoom_allowed = ctrl_q[`CTRL_ZOOM] && (!rolling_q || !running);
  assign o_running      = running;
  assign o_adc_ready    = in_take;

endmodule

// >>> rtl/wfm_acq_map.svh
`ifndef WFM_ACQ_MAP_SVH
`define WFM_ACQ_MAP_SVH

// Register offsets (byte addresses, one word each)
`define ADDR_CTRL       8'h00
`define ADDR_MODE       8'h04
`define ADDR_RATIO      8'h08
`define ADDR_RECLEN     8'h0c
`define ADDR_AVGCNT     8'h10
`define ADDR_NSINGLE    8'h14
`define ADDR_ROLL       8'h18
`define ADDR_STATUS     8'h1c
`define ADDR_ACQDONE    8'h20

// Control bit positions
`define CTRL_RUN        0
`define CTRL_SINGLE     1
`define CTRL_CLEAR      2
`define CTRL_RECAUTO    3
`define CTRL_ROLLEN     4
`define CTRL_ZOOM       5

// Reset values
`define RST_RATIO       16'h0001
`define RST_RECLEN      16'h0400
`define RST_AUTO_RECLEN 16'h0400
`define RST_AVGCNT      8'h10
`define RST_NSINGLE     8'h01
`define RST_ROLL        16'h0064
`define RST_TDIV        16'h0001

// Field widths
`define SAMPLE_W        12
`define ACC_W           32
`define RECLEN_W        16

`endif

// >>> rtl/wfm_acq_pkg.sv
package wfm_acq_pkg;

  typedef enum logic [2:0] {
    MODE_SAMPLE    = 3'b000,
    MODE_MINMAX    = 3'b001,
    MODE_GROUP_AVG = 3'b010,
    MODE_AVERAGE   = 3'b011,
    MODE_AVG_HR    = 3'b100,
    MODE_ENV       = 3'b101,
    MODE_ENV_PD    = 3'b110,
    MODE_ENV_HR    = 3'b111
  } acq_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b10
  } acq_state_e;

endpackage

// >>> verification/adc_model.sv
`timescale 1ns/1ps
module adc_model (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_nrst,
  // Pacing and handshake
  input  wire logic        i_slow,
  input  wire logic        i_ready,
  output logic      [11:0] o_data,
  output logic             o_valid
);
  logic [11:0] cnt_q, cnt_d, data_d;
  logic        valid_d;

  // Scrambled ramp so that each group spanning a 12-bit wrap of the product holds unordered values
  function automatic logic [11:0] wave(input logic [11:0] k);
    return (k * 12'h2d5) ^ 12'h03c;
  endfunction

  always_comb begin
    cnt_d   = cnt_q;
    data_d  = o_data;
    valid_d = o_valid;
    if (o_valid && i_ready) begin
      cnt_d   = cnt_q + 12'h001;
      valid_d = !i_slow;
      // A gap shows inverted data, so a stale sample is never mistaken for a new one
      data_d  = i_slow ? ~o_data : wave(cnt_q + 12'h001);
    end else if (!o_valid) begin
      valid_d = 1'b1;
      data_d  = wave(cnt_q);
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q   <= 12'h000;
      o_data  <= 12'hfff;
      o_valid <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      o_data  <= data_d;
      o_valid <= valid_d;
    end
  end
endmodule

// >>> verification/test_wfm_acq.sv
`timescale 1ns/1ps
`include "wfm_acq_map.svh"
module test_wfm_acq;
  logic        clk, nrst, wr, rd, av, ar, pv, pr, slow, roll, zok, run;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, cyc;
  logic [11:0] ad, lo, hi;
  logic [15:0] tdiv;
  logic [11:0] smp[$];
  logic [23:0] pts[$];
  int          num_errors, total_checks;
  int          mtab[9] = '{0, 0, 1, 2, 3, 4, 5, 6, 7};
  int          rtab[9] = '{4, 0, 4, 4, 1, 2, 1, 2, 2};
  int          ntab[9] = '{1, 1, 1, 1, 2, 2, 2, 2, 2};
  logic [7:0]  rst_a[6] = '{`ADDR_RATIO, `ADDR_RECLEN, `ADDR_AVGCNT, `ADDR_NSINGLE, `ADDR_ROLL, 8'h24};
  logic [31:0] rst_v[6] = '{`RST_RATIO, `RST_RECLEN, `RST_AVGCNT, `RST_NSINGLE, `RST_ROLL, 32'h0};

  wfm_acq i_wfm_acq (
    .i_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .i_adc_data(ad), .i_adc_valid(av), .o_adc_ready(ar), .i_trigger(1'b0), .i_time_per_div(tdiv),
    .o_pt_lo(lo), .o_pt_hi(hi), .o_pt_index(), .o_pt_valid(pv), .i_pt_ready(pr),
    .o_rolling(roll), .o_zoom_allowed(zok), .o_running(run)
  );
  adc_model i_adc_model (.i_clk(clk), .i_nrst(nrst), .i_slow(slow), .i_ready(ar), .o_data(ad), .o_valid(av));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Sink stalls one cycle in four to exercise the output buffer
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    pr  <= (cyc[1:0] != 2'h3);
    if (av && ar) smp.push_back(ad);
    if (pv && pr) pts.push_back({lo, hi});
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] l, input logic [31:0] h);
    total_checks++;
    if (((got >= l) && (got <= h)) !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %s expected %0h..%0h seen %0h", what, l, h, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input string what);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(what, rdata, e, e);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wait_done(input int cnt);
    int k = 0;
    repeat (4) @(posedge clk);
    while ((run !== 1'b0 || pts.size() < cnt) && k < 3000) begin
      @(posedge clk);
      k++;
    end
    if (k == 3000) begin
      num_errors++;
      $display("[FAIL] acquisition end expected within 3000 cycles seen none");
      give_verdict();
    end
  endtask

  task automatic run_mode(input int m, input int ratio, input int ns);
    int          n, b;
    logic [31:0] mn, mx, sm, t, pl, ph;
    logic [31:0] rlo[4], rhi[4];
    n = (ratio == 0) ? 1 : ratio;
    t = (m == 2 || m == 4 || m == 7) ? 32'h1 : 32'h0;
    slow <= m[0];
    wr_reg(`ADDR_MODE, m);
    wr_reg(`ADDR_RATIO, ratio);
    wr_reg(`ADDR_NSINGLE, ns);
    smp.delete();
    pts.delete();
    wr_reg(`ADDR_CTRL, 32'h6);
    wait_done(4 * ns);
    chk("sample count", smp.size(), 4 * n * ns, 4 * n * ns);
    chk("point count", pts.size(), 4 * ns, 4 * ns);
    for (int a = 0; a < ns; a++) begin
      for (int k = 0; k < 4; k++) begin
        b  = (a * 4 + k) * n;
        mn = smp[b];
        mx = smp[b];
        sm = 32'h0;
        for (int i = 0; i < n; i++) begin
          sm = sm + smp[b + i];
          if (smp[b + i] < mn) mn = smp[b + i];
          if (smp[b + i] > mx) mx = smp[b + i];
        end
        // Mean may be truncated or rounded, so one step of slack
        if (t == 32'h1) begin
          mn = sm / n;
          mx = mn;
        end
        if (a == 0 || mn < rlo[k]) rlo[k] = mn;
        if (a == 0 || mx > rhi[k]) rhi[k] = mx;
        pl = pts[a * 4 + k][23:12];
        ph = pts[a * 4 + k][11:0];
        case (m)
          0: chk("sample point", pl, mn, mx);
          1: begin
            chk("group min", pl, mn, mn);
            chk("group max", ph, mx, mx);
          end
          2: chk("group mean", pl, mn, mn + t);
          3, 4: chk("average", pl, rlo[k], rhi[k] + t);
          default: begin
            chk("envelope low", pl, rlo[k], rlo[k] + t);
            chk("envelope high", ph, rhi[k], rhi[k] + t);
          end
        endcase
      end
    end
    $display("test mode %0d ratio %0d done", m, ratio);
  endtask

  initial begin
    cyc          = 32'h0;
    nrst         = 1'b0;
    wr           = 1'b0;
    rd           = 1'b0;
    addr         = 8'h00;
    wdata        = 32'h0;
    slow         = 1'b0;
    pr           = 1'b1;
    tdiv         = 16'h0001;
    num_errors   = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) rd_reg(rst_a[i], rst_v[i], "reset value");
    wr_reg(8'h24, 32'hffffffff);
    rd_reg(8'h24, 32'h0, "unmapped");
    wr_reg(`ADDR_AVGCNT, 32'h5);
    rd_reg(`ADDR_AVGCNT, 32'h5, "average count");
    wr_reg(`ADDR_CTRL, 32'h0);
    wr_reg(`ADDR_RECLEN, 32'h4);
    rd_reg(`ADDR_RECLEN, 32'h4, "manual record length");
    $display("test registers done");
    for (int i = 0; i < 9; i++) run_mode(mtab[i], rtab[i], ntab[i]);
    tdiv <= 16'h0063;
    wr_reg(`ADDR_RATIO, 32'h1);
    wr_reg(`ADDR_MODE, 32'h0);
    wr_reg(`ADDR_CTRL, 32'h11);
    settle(3);
    chk("rolling below threshold", roll, 0, 0);
    tdiv <= 16'h0064;
    settle(3);
    chk("rolling at threshold", roll, 1, 1);
    pts.delete();
    rd_reg(`ADDR_RECLEN, `RST_AUTO_RECLEN, "rolling record length");
    settle(20);
    chk("rolling points", pts.size(), 1, 32'hffff);
    wr_reg(`ADDR_CTRL, 32'h31);
    settle(2);
    chk("zoom while running", zok, 0, 0);
    wr_reg(`ADDR_CTRL, 32'h30);
    settle(2);
    chk("zoom while stopped", zok, 1, 1);
    $display("test roll done");
    give_verdict();
  end
endmodule

// >>> verification/wfm_acq_checker.sv
`timescale 1ns/1ps
module wfm_acq_checker (
  // Clock and reset
  input wire logic        i_clk,
  input wire logic        i_nrst,
  // Register port
  input wire logic [7:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  // Sample stream
  input wire logic [11:0] i_adc_data,
  input wire logic        i_adc_valid,
  input wire logic        o_adc_ready,
  input wire logic        i_trigger,
  input wire logic [15:0] i_time_per_div,
  // Point stream
  input wire logic [11:0] o_pt_lo,
  input wire logic [11:0] o_pt_hi,
  input wire logic [15:0] o_pt_index,
  input wire logic        o_pt_valid,
  input wire logic        i_pt_ready,
  // Status
  input wire logic        o_rolling,
  input wire logic        o_zoom_allowed,
  input wire logic        o_running
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_stall;
    o_pt_valid && !i_pt_ready;
  endsequence
  sequence s_held;
    o_pt_valid && $stable(o_pt_lo) && $stable(o_pt_hi) && $stable(o_pt_index);
  endsequence

  chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside the read answer cycle");
  chk_point_hold: assert property (s_stall |=> s_held)
    else $error("point changed while the sink stalled");
  chk_point_release: assert property ($fell(o_pt_valid) |-> $past(i_pt_ready))
    else $error("point withdrawn without a handshake");
  chk_min_below_max: assert property (o_pt_valid |-> o_pt_lo <= o_pt_hi)
    else $error("point low value above high value");
  chk_point_cause: assert property ($rose(o_pt_valid) |-> $past(i_adc_valid && o_adc_ready, 2))
    else $error("point appeared without a closing sample two cycles before");
  chk_take_valid: assert property (o_adc_ready |-> i_adc_valid)
    else $error("sample ready raised without valid");
  chk_take_running: assert property (o_adc_ready |-> o_running)
    else $error("sample taken while acquisition stopped");
  chk_zoom_stopped: assert property (o_rolling && o_running |-> !o_zoom_allowed)
    else $error("zoom allowed while rolling and running");
endmodule

bind wfm_acq wfm_acq_checker i_wfm_acq_checker (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_adc_data(i_adc_data), .i_adc_valid(i_adc_valid), .o_adc_ready(o_adc_ready),
  .i_trigger(i_trigger), .i_time_per_div(i_time_per_div), .o_pt_lo(o_pt_lo), .o_pt_hi(o_pt_hi),
  .o_pt_index(o_pt_index), .o_pt_valid(o_pt_valid), .i_pt_ready(i_pt_ready), .o_rolling(o_rolling),
  .o_zoom_allowed(o_zoom_allowed), .o_running(o_running)
);
